/* File: hdl/completion_timer.sv */
`timescale 1ns/1ps
module completion_timer (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic clear_in,
   input wire logic run_in,
   input wire logic limit_on_in,
   input wire logic [39:0] limit_us_in,
   output logic expired_out
);
   logic [4:0] pre;
   logic [39:0] us_count;
   logic [4:0] next_pre;
   logic [39:0] next_us_count;

   // Microsecond prescaler and elapsed count
   always_comb begin
      next_pre = pre;
      next_us_count = us_count;
      if (clear_in) begin
         next_pre = 5'h00;
         next_us_count = 40'h00_0000_0000;
      end else if (run_in && !expired_out) begin
         if (pre == 5'(stream_read_pkg::CYCLES_PER_US - 1)) begin
            next_pre = 5'h00;
            next_us_count = us_count + 40'h00_0000_0001;
         end else begin
            next_pre = pre + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         pre <= 5'h00;
         us_count <= 40'h00_0000_0000;
      end else if (ce_in) begin
         pre <= next_pre;
         us_count <= next_us_count;
      end
   end

   // No limit means never expires
   assign expired_out = limit_on_in && (us_count >= limit_us_in);
endmodule : completion_timer

/* File: hdl/stream_read_dma_command.sv */
`timescale 1ns/1ps
module stream_read_dma_command (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic tf_write_in,
   input wire logic [2:0] tf_sel_in,
   input wire logic [7:0] tf_data_in,
   input wire logic tf_status_read_in,
   input wire logic [31:0] time_unit_us_in,
   input wire logic [63:0] default_limit_in,
   input wire logic [15:0] media_data_in,
   input wire logic media_valid_in,
   input wire logic [3:0] media_fault_in,
   input wire logic dma_ack_in,
   output logic media_ready_out,
   output logic media_start_out,
   output logic [15:0] dma_data_out,
   output logic dma_req_out,
   output logic [7:0] drive_condition_out,
   output logic [7:0] error_report_out,
   output logic [4:0] error_log_out,
   output logic intrq_out,
   output logic urgent_request_out,
   output logic non_sequential_hint_out,
   output logic resume_error_recovery_out,
   output logic [2:0] stream_identifier_out
);
   stream_read_pkg::cmd_state_t state, next_state;
   logic [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev;
   logic [7:0] next_feat_cur, next_feat_prev, next_cnt_cur, next_cnt_prev;
   logic [16:0] sectors_left, next_sectors_left;
   logic [7:0] words_left, next_words_left;
   logic [15:0] hold_data, next_hold_data;
   logic hold_full, next_hold_full, media_ready, next_media_ready;
   logic [7:0] status, next_status, error_reg, next_error_reg;
   logic [4:0] log_bits, next_log_bits;
   logic intrq, next_intrq, start, next_start, cont, next_cont;
   logic urgent, next_urgent, nonseq, next_nonseq, resume, next_resume;
   logic [2:0] sid, next_sid;
   logic [39:0] limit_us, next_limit_us;
   logic limit_on, next_limit_on;
   logic accept, take, drain, expired;
   logic [7:0] limit_byte;

   // Per-stream default limit, picked by stream identifier
   function automatic logic [7:0] default_for(input logic [63:0] table_in,
                                              input logic [2:0] id);
      default_for = table_in[{id, 3'h0} +: 8];
   endfunction : default_for

   assign accept = tf_write_in && tf_sel_in == stream_read_pkg::SEL_COMMAND
      && tf_data_in == stream_read_pkg::OPC_STREAM_READ
      && !status[stream_read_pkg::ST_BUSY];
   assign take = media_valid_in && media_ready;
   assign drain = hold_full && dma_ack_in;
   // Zero falls back to the stream default; zero there means no limit
   assign limit_byte = (feat_prev != 8'h00) ? feat_prev
      : default_for(default_limit_in, feat_cur[2:0]);

   // Timer cleared by the command write, runs until ending status
   completion_timer u_timer (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .clear_in(accept),
      .run_in(state == stream_read_pkg::S_XFER),
      .limit_on_in(limit_on),
      .limit_us_in(limit_us),
      .expired_out(expired)
   );

   // Task-file shadow registers: a write pushes current into previous
   always_comb begin
      next_feat_cur = feat_cur;
      next_feat_prev = feat_prev;
      next_cnt_cur = cnt_cur;
      next_cnt_prev = cnt_prev;
      if (tf_write_in && tf_sel_in == stream_read_pkg::SEL_FEATURE) begin
         next_feat_prev = feat_cur;
         next_feat_cur = tf_data_in;
      end
      if (tf_write_in && tf_sel_in == stream_read_pkg::SEL_COUNT) begin
         next_cnt_prev = cnt_cur;
         next_cnt_cur = tf_data_in;
      end
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         feat_cur <= 8'h00;
         feat_prev <= 8'h00;
         cnt_cur <= 8'h00;
         cnt_prev <= 8'h00;
      end else if (ce_in) begin
         feat_cur <= next_feat_cur;
         feat_prev <= next_feat_prev;
         cnt_cur <= next_cnt_cur;
         cnt_prev <= next_cnt_prev;
      end
   end

   // Command sequencing, data path and ending status
   always_comb begin
      next_state = state;
      next_sectors_left = sectors_left;
      next_words_left = words_left;
      next_hold_data = hold_data;
      next_hold_full = hold_full;
      next_status = status;
      next_error_reg = error_reg;
      next_log_bits = log_bits;
      next_intrq = intrq;
      next_start = 1'b0;
      next_cont = cont;
      next_urgent = urgent;
      next_nonseq = nonseq;
      next_resume = resume;
      next_sid = sid;
      next_limit_us = limit_us;
      next_limit_on = limit_on;
      // Set wins: a completion in the read cycle keeps the interrupt
      if (tf_status_read_in) begin
         next_intrq = 1'b0;
      end
      unique case (state)
         stream_read_pkg::S_IDLE: begin
            if (accept) begin
               next_state = stream_read_pkg::S_XFER;
               next_start = 1'b1;
               if ({cnt_prev, cnt_cur} == 16'h0000) begin
                  next_sectors_left = stream_read_pkg::MAX_SECTORS;
               end else begin
                  next_sectors_left =
                     {1'b0, cnt_prev, cnt_cur};
               end
               next_words_left = stream_read_pkg::WORDS_PER_SECTOR_M1;
               next_cont = feat_cur[stream_read_pkg::FEAT_CONT];
               next_urgent = feat_cur[stream_read_pkg::FEAT_URGENT];
               next_nonseq = feat_cur[stream_read_pkg::FEAT_NONSEQ];
               next_resume = feat_cur[stream_read_pkg::FEAT_RESUME];
               next_sid = feat_cur[stream_read_pkg::STREAM_IDENTIFIER_W-1:0];
               next_limit_us = {32'h0000_0000, limit_byte}
                  * {8'h00, time_unit_us_in};
               next_limit_on = limit_byte != 8'h00;
               next_log_bits = 5'h00;
               next_error_reg = stream_read_pkg::ERROR_RESET;
               next_status = stream_read_pkg::STATUS_RESET;
               next_status[stream_read_pkg::ST_BUSY] = 1'b1;
               next_intrq = 1'b0;
            end else if (tf_write_in && !status[stream_read_pkg::ST_BUSY]
                         && tf_sel_in == stream_read_pkg::SEL_COMMAND) begin
               // Any other code is refused at once
               next_error_reg = stream_read_pkg::ERROR_RESET;
               next_error_reg[stream_read_pkg::ER_COMMAND_ABORTED] = 1'b1;
               next_status = stream_read_pkg::STATUS_RESET;
               next_status[stream_read_pkg::ST_ERR] = 1'b1;
               next_intrq = 1'b1;
            end
         end
         stream_read_pkg::S_XFER: begin
            if (take) begin
               next_log_bits[3:0] = log_bits[3:0] | media_fault_in;
               next_hold_data = media_data_in;
               // Without continuous mode the faulty word is not delivered
               next_hold_full = cont || media_fault_in == 4'h0;
            end
            if (drain) begin
               next_hold_full = 1'b0;
               next_words_left = words_left - 8'h01;
               if (words_left == 8'h00) begin
                  next_words_left = stream_read_pkg::WORDS_PER_SECTOR_M1;
                  next_sectors_left = sectors_left - 17'h0_0001;
               end
            end
            if (expired) begin
               // Conflicting texts on stream error here: left clear
               next_log_bits[stream_read_pkg::LOG_TIMEOUT] = 1'b1;
               next_state = stream_read_pkg::S_DONE;
            end else if (take && !cont && media_fault_in != 4'h0) begin
               next_state = stream_read_pkg::S_DONE;
            end else if (drain && words_left == 8'h00
                         && sectors_left == 17'h0_0001) begin
               next_state = stream_read_pkg::S_DONE;
            end
            if (next_state == stream_read_pkg::S_DONE) begin
               next_hold_full = 1'b0;
               next_status = stream_read_pkg::STATUS_RESET;
               next_intrq = 1'b1;
               if (cont) begin
                  // Error bit never set in continuous mode
                  next_status[stream_read_pkg::ST_STREAM_ERR] =
                     !next_log_bits[stream_read_pkg::LOG_TIMEOUT]
                     && next_log_bits[3:0] != 4'h0;
               end else if (next_log_bits != 5'h00) begin
                  next_status[stream_read_pkg::ST_ERR] = 1'b1;
                  next_error_reg[stream_read_pkg::ER_CRC] =
                     next_log_bits[stream_read_pkg::LOG_CRC];
                  next_error_reg[stream_read_pkg::ER_UNC] =
                     next_log_bits[stream_read_pkg::LOG_UNC];
                  next_error_reg[stream_read_pkg::ER_SECTOR_NOT_FOUND] =
                     next_log_bits[stream_read_pkg::LOG_SECTOR_NOT_FOUND];
                  next_error_reg[stream_read_pkg::ER_COMMAND_ABORTED] =
                     next_log_bits[stream_read_pkg::LOG_COMMAND_ABORTED]
                     || next_log_bits[stream_read_pkg::LOG_TIMEOUT];
               end
            end
         end
         stream_read_pkg::S_DONE: begin
            next_state = stream_read_pkg::S_IDLE;
         end
         default: begin
            next_state = stream_read_pkg::S_IDLE;
         end
      endcase
      // One word in flight; ready drops after each take to avoid overrun
      next_media_ready = next_state == stream_read_pkg::S_XFER
         && !next_hold_full && !take;
      next_status[stream_read_pkg::ST_DRQ] = next_hold_full;
   end

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= stream_read_pkg::S_IDLE;
         sectors_left <= 17'h0_0000;
         words_left <= 8'h00;
         hold_data <= 16'h0000;
         hold_full <= 1'b0;
         media_ready <= 1'b0;
         status <= stream_read_pkg::STATUS_RESET;
         error_reg <= stream_read_pkg::ERROR_RESET;
         log_bits <= 5'h00;
         intrq <= 1'b0;
         start <= 1'b0;
         cont <= 1'b0;
         urgent <= 1'b0;
         nonseq <= 1'b0;
         resume <= 1'b0;
         sid <= 3'h0;
         limit_us <= 40'h00_0000_0000;
         limit_on <= 1'b0;
      end else if (ce_in) begin
         state <= next_state;
         sectors_left <= next_sectors_left;
         words_left <= next_words_left;
         hold_data <= next_hold_data;
         hold_full <= next_hold_full;
         media_ready <= next_media_ready;
         status <= next_status;
         error_reg <= next_error_reg;
         log_bits <= next_log_bits;
         intrq <= next_intrq;
         start <= next_start;
         cont <= next_cont;
         urgent <= next_urgent;
         nonseq <= next_nonseq;
         resume <= next_resume;
         sid <= next_sid;
         limit_us <= next_limit_us;
         limit_on <= next_limit_on;
      end
   end

   // All outputs straight from flip-flops
   assign media_ready_out = media_ready;
   assign media_start_out = start;
   assign dma_data_out = hold_data;
   assign dma_req_out = hold_full;
   assign drive_condition_out = status;
   assign error_report_out = error_reg;
   assign error_log_out = log_bits;
   assign intrq_out = intrq;
   assign urgent_request_out = urgent;
   assign non_sequential_hint_out = nonseq;
   assign resume_error_recovery_out = resume;
   assign stream_identifier_out = sid;

   // Checks run only while the clock enable is high
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in || !ce_in);

   sequence timeout_end_s;
      state == stream_read_pkg::S_DONE
      && log_bits[stream_read_pkg::LOG_TIMEOUT]
      && !status[stream_read_pkg::ST_BUSY];
   endsequence

   opcode_start_a: assert property (
      accept |=> state == stream_read_pkg::S_XFER
      && status[stream_read_pkg::ST_BUSY] && start)
      else $error("stream read not started");
   count_load_a: assert property (
      accept && {cnt_prev, cnt_cur} != 16'h0000
      |=> sectors_left == {1'b0, $past(cnt_prev), $past(cnt_cur)})
      else $error("sector count assembled wrongly");
   zero_count_a: assert property (
      accept && {cnt_prev, cnt_cur} == 16'h0000
      |=> sectors_left == stream_read_pkg::MAX_SECTORS)
      else $error("zero count not taken as maximum");
   normal_stop_a: assert property (
      state == stream_read_pkg::S_XFER
      && !cont && take && media_fault_in != 4'h0 && !expired
      |=> state == stream_read_pkg::S_DONE
      && status[stream_read_pkg::ST_ERR])
      else $error("normal read did not stop on fault");
   cont_no_err_a: assert property (
      $fell(status[stream_read_pkg::ST_BUSY])
      && cont |-> !status[stream_read_pkg::ST_ERR])
      else $error("error bit set in continuous mode");
   stream_err_a: assert property (
      $fell(status[stream_read_pkg::ST_BUSY])
      && cont && !log_bits[stream_read_pkg::LOG_TIMEOUT]
      |-> status[stream_read_pkg::ST_STREAM_ERR]
      == (log_bits[3:0] != 4'h0))
      else $error("stream error flag wrong");
   timeout_stop_a: assert property (
      state == stream_read_pkg::S_XFER && expired
      |=> timeout_end_s ##1 state == stream_read_pkg::S_IDLE)
      else $error("timeout did not end command");
   busy_irq_a: assert property (
      $fell(status[stream_read_pkg::ST_BUSY])
      |-> intrq_out && !dma_req_out)
      else $error("busy dropped without interrupt");
   stream_sel_a: assert property (
      accept |=> stream_identifier_out == $past(feat_cur[2:0])
      && urgent_request_out
      == $past(feat_cur[stream_read_pkg::FEAT_URGENT]))
      else $error("stream parameters not latched");
endmodule : stream_read_dma_command

/* File: hdl/stream_read_pkg.sv */
package stream_read_pkg;
   // Command code of the streaming DMA read
   localparam logic [7:0] OPC_STREAM_READ = 8'h2A;
   // Feature byte field positions
   localparam int FEAT_URGENT = 7;
   localparam int FEAT_CONT = 6;
   localparam int FEAT_NONSEQ = 5;
   localparam int FEAT_RESUME = 4;
   localparam int STREAM_IDENTIFIER_W = 3;
   // Task-file register selects
   localparam logic [2:0] SEL_FEATURE = 3'h1;
   localparam logic [2:0] SEL_COUNT = 3'h2;
   localparam logic [2:0] SEL_COMMAND = 3'h7;
   // Drive condition bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_READY = 6;
   localparam int ST_STREAM_ERR = 5;
   localparam int ST_SEEK_DONE = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   // Error report bit positions
   localparam int ER_CRC = 7;
   localparam int ER_UNC = 6;
   localparam int ER_SECTOR_NOT_FOUND = 4;
   localparam int ER_COMMAND_ABORTED = 2;
   // Error log bit positions; fault inputs use the low four
   localparam int LOG_CRC = 0;
   localparam int LOG_UNC = 1;
   localparam int LOG_SECTOR_NOT_FOUND = 2;
   localparam int LOG_COMMAND_ABORTED = 3;
   localparam int LOG_TIMEOUT = 4;
   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h50;
   localparam logic [7:0] ERROR_RESET = 8'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int US_NS = 1000;
   localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;
   // Transfer sizes
   localparam logic [7:0] WORDS_PER_SECTOR_M1 = 8'hFF;
   localparam logic [16:0] MAX_SECTORS = 17'h1_0000;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_XFER = 3'b010,
      S_DONE = 3'b100
   } cmd_state_t;
endpackage : stream_read_pkg

/* File: sim/host_adapter_model.sv */
`timescale 1ns/1ps
module host_adapter_model (
   input wire logic mclk_in,
   input wire logic dma_req_in,
   input wire logic stall_in,
   output logic tf_write_out,
   output logic [2:0] tf_sel_out,
   output logic [7:0] tf_data_out,
   output logic tf_status_read_out,
   output logic dma_ack_out
);
   // Idle levels at time zero
   initial begin
      tf_write_out = 1'b0;
      tf_sel_out = 3'h0;
      tf_data_out = 8'h00;
      tf_status_read_out = 1'b0;
      dma_ack_out = 1'b0;
   end

   // Ack one cycle after request, then drop so each word pairs once
   always @(posedge mclk_in) begin
      dma_ack_out <= dma_req_in && !dma_ack_out && !stall_in;
   end

   // One-cycle write strobe; released lines show inverted data
   task automatic write_reg(input logic [2:0] sel, input logic [7:0] data);
      @(posedge mclk_in);
      tf_write_out <= 1'b1;
      tf_sel_out <= sel;
      tf_data_out <= data;
      @(posedge mclk_in);
      tf_write_out <= 1'b0;
      tf_sel_out <= ~sel;
      tf_data_out <= ~data;
   endtask : write_reg

   // Full command: limit then control, count high then low, then code
   task automatic issue_command(input logic [7:0] limit_byte,
         input logic [7:0] control, input logic [15:0] count,
         input logic [7:0] opcode);
      write_reg(stream_read_pkg::SEL_FEATURE, limit_byte);
      write_reg(stream_read_pkg::SEL_FEATURE, control);
      write_reg(stream_read_pkg::SEL_COUNT, count[15:8]);
      write_reg(stream_read_pkg::SEL_COUNT, count[7:0]);
      write_reg(stream_read_pkg::SEL_COMMAND, opcode);
   endtask : issue_command

   // Status read acknowledges the interrupt
   task automatic read_status;
      @(posedge mclk_in);
      tf_status_read_out <= 1'b1;
      @(posedge mclk_in);
      tf_status_read_out <= 1'b0;
   endtask : read_status
endmodule : host_adapter_model

/* File: sim/stream_read_dma_command_test.sv */
`timescale 1ns/1ps
module stream_read_dma_command_test;
   logic mclk_in, reset_in, ce_in, tf_write_in, tf_status_read_in;
   logic [2:0] tf_sel_in;
   logic [7:0] tf_data_in;
   logic [31:0] time_unit_us_in;
   logic [63:0] default_limit_in;
   logic [15:0] media_data_in;
   logic media_valid_in, dma_ack_in, media_ready_out, media_start_out;
   logic [3:0] media_fault_in;
   logic [15:0] dma_data_out;
   logic dma_req_out, intrq_out, urgent_request_out;
   logic non_sequential_hint_out, resume_error_recovery_out;
   logic [7:0] drive_condition_out, error_report_out;
   logic [4:0] error_log_out;
   logic [2:0] stream_identifier_out;
   logic [15:0] fault_at, expected_word;
   logic [3:0] fault_kind;
   logic dma_stall, slow_host, data_check;
   int num_errors, check_count, cycles, words;

   stream_read_dma_command stream_read_dma_command_i (.*);
   host_adapter_model host_adapter_model_i (.mclk_in(mclk_in),
      .dma_req_in(dma_req_out), .stall_in(dma_stall),
      .tf_write_out(tf_write_in), .tf_sel_out(tf_sel_in),
      .tf_data_out(tf_data_in), .tf_status_read_out(tf_status_read_in),
      .dma_ack_out(dma_ack_in));

   // Fault travels with the word it marks
   assign media_fault_in = (media_data_in == fault_at) ? fault_kind : 4'h0;

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Hang guard, well above the longest expected run
   always @(posedge mclk_in) begin
      cycles++;
      dma_stall <= slow_host && cycles[1];
      if (cycles == 30000) begin
         num_errors++;
         conclude();
      end
   end

   // Media source counts words; DMA monitor checks order and count
   always @(posedge mclk_in) begin
      if (media_valid_in && media_ready_out) begin
         media_data_in <= media_data_in + 16'h0001;
      end
      if (dma_req_out === 1'b1 && dma_ack_in === 1'b1) begin
         if (data_check) begin
            check(dma_data_out, expected_word);
         end
         expected_word = expected_word + 16'h0001;
         words++;
      end
   end

   // Ending flags as {busy, stream error, error}
   task automatic check_end(input logic [2:0] exp);
      check({drive_condition_out[stream_read_pkg::ST_BUSY],
             drive_condition_out[stream_read_pkg::ST_STREAM_ERR],
             drive_condition_out[stream_read_pkg::ST_ERR]}, exp);
   endtask : check_end

   task automatic wait_intrq(input int bound);
      int n;
      n = 0;
      while (intrq_out !== 1'b1 && n < bound) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      check(intrq_out, 1'b1);
      media_valid_in <= 1'b0;
   endtask : wait_intrq

   // Media starts from word zero for each command
   task automatic start(input logic [7:0] limit_b, input logic [7:0] ctrl,
         input logic [15:0] count);
      media_valid_in <= 1'b0;
      media_data_in <= 16'h0000;
      expected_word = 16'h0000;
      words = 0;
      host_adapter_model_i.issue_command(limit_b, ctrl, count,
         stream_read_pkg::OPC_STREAM_READ);
      media_valid_in <= 1'b1;
   endtask : start

   initial begin
      reset_in = 1'b1;
      ce_in = 1'b1;
      time_unit_us_in = 32'h0000_0001;
      default_limit_in = 64'h0000_0000_0000_0000;
      media_data_in = 16'h0000;
      media_valid_in = 1'b0;
      fault_at = 16'hFFFF;
      fault_kind = 4'h0;
      slow_host = 1'b0;
      data_check = 1'b1;
      repeat (4) @(posedge mclk_in);
      reset_in <= 1'b0;
      @(posedge mclk_in);
      #1;
      check(drive_condition_out, stream_read_pkg::STATUS_RESET);
      check({error_report_out, 3'h0, error_log_out}, 16'h0000);
      // Unknown code is aborted, not started
      host_adapter_model_i.issue_command(8'h00, 8'h00, 16'h0001, 8'h25);
      wait_intrq(10);
      check(error_report_out[stream_read_pkg::ER_COMMAND_ABORTED], 1'b1);
      check(media_start_out, 1'b0);
      host_adapter_model_i.read_status();
      #1;
      check(intrq_out, 1'b0);
      // Urgent, hint, resume, stream 5; second code while busy ignored
      start(8'h00, 8'hB5, 16'h0001);
      host_adapter_model_i.write_reg(stream_read_pkg::SEL_COMMAND, 8'h00);
      #1;
      check(urgent_request_out, 1'b1);
      check(non_sequential_hint_out, 1'b1);
      check(resume_error_recovery_out, 1'b1);
      check(stream_identifier_out, 3'h5);
      check_end(3'b100);
      wait_intrq(3000);
      check(words, 256);
      check_end(3'b000);
      check(error_report_out, 8'h00);
      host_adapter_model_i.read_status();
      // Two sectors, low byte only; stalling host
      slow_host = 1'b1;
      start(8'h00, 8'h02, 16'h0002);
      wait_intrq(6000);
      check(words, 512);
      host_adapter_model_i.read_status();
      // Continuous mode, each fault kind once
      for (int k = 0; k < 4; k++) begin
         fault_at = 16'h0005 + 16'(k);
         fault_kind = 4'(1 << k);
         slow_host = k[0];
         start(8'h00, 8'h40, 16'h0001);
         wait_intrq(3000);
         check(words, 256);
         check_end(3'b010);
         check(error_log_out[k], 1'b1);
         host_adapter_model_i.read_status();
      end
      // Ordinary mode stops on an uncorrectable word
      data_check = 1'b0;
      fault_at = 16'h0003;
      fault_kind = 4'h2;
      start(8'h00, 8'h00, 16'h0001);
      wait_intrq(3000);
      check_end(3'b001);
      check(error_report_out[stream_read_pkg::ER_UNC], 1'b1);
      // Faulty fourth word is dropped, three delivered
      check(words, 3);
      host_adapter_model_i.read_status();
      // Time limit from limit byte, then from stream default; count 0
      // Unit 1 us then 2 us, so the limit is 20 then 40 cycles
      fault_at = 16'hFFFF;
      for (int t = 0; t < 2; t++) begin
         default_limit_in = (t == 1) ? 64'h0000_0000_0100_0000 : 64'h0;
         time_unit_us_in = 32'(t + 1);
         start((t == 0) ? 8'h01 : 8'h00, (t == 0) ? 8'h40 : 8'h43,
            16'h0000);
         // Still busy short of the limit: catches a unit left out
         repeat (15 + 15 * t) @(posedge mclk_in);
         #1;
         check_end(3'b100);
         wait_intrq(40);
         check(error_log_out[stream_read_pkg::LOG_TIMEOUT], 1'b1);
         check_end(3'b000);
         host_adapter_model_i.read_status();
      end
      conclude();
   end
endmodule : stream_read_dma_command_test
